// ---- src/pbo_map.svh ----
// constants of the bridge forwarding and ordering block
`ifndef PBO_MAP_SVH
`define PBO_MAP_SVH

// bus command codes
`define PBO_CMD_IOR 4'h2
`define PBO_CMD_IOW 4'h3
`define PBO_CMD_MR 4'h6
`define PBO_CMD_MW 4'h7
`define PBO_CMD_CFGR 4'hA
`define PBO_CMD_CFGW 4'hB
`define PBO_CMD_MRM 4'hC
`define PBO_CMD_MRL 4'hE
`define PBO_CMD_MWI 4'hF

// vga frame buffer window
`define PBO_FB_LO 32'h000A0000
`define PBO_FB_HI 32'h000BFFFF

// vga i/o ranges, low ten bits after aliasing
`define PBO_VIO0_LO 10'h3B0
`define PBO_VIO0_HI 10'h3BB
`define PBO_VIO1_LO 10'h3C0
`define PBO_VIO1_HI 10'h3DF
`define PBO_PAL0 10'h3C6
`define PBO_PAL1 10'h3C8
`define PBO_PAL2 10'h3C9
`define PBO_IO_UP_LSB 16
`define PBO_IO_UP_MSB 31
`define PBO_IO_ALIAS_MSB 9

// posted write queue
`define PBO_PW_DEPTH 16
`define PBO_PW_WIDTH 73
`define PBO_CNT_W 5
`define PBO_CNT_RST 5'h00
`define PBO_DATA_RST 32'h00000000

`endif

// ---- src/pbo_pkg.sv ----
// types shared by the bridge forwarding and ordering block
package pbo_pkg;
  typedef logic [3:0] pbo_cmd_t;
  typedef logic [31:0] pbo_addr_t;
  typedef logic [3:0] pbo_be_t;
  typedef logic [31:0] pbo_data_t;
  typedef enum logic [1:0] {PBO_DT_IDLE, PBO_DT_PEND, PBO_DT_DONE} pbo_dt_e;
  typedef struct packed {
    logic last;
    pbo_cmd_t cmd;
    pbo_be_t be;
    pbo_addr_t addr;
    pbo_data_t data;
  } pbo_pw_s;
endpackage

// ---- src/pbo_fifo.sv ----
// posted write queue, first word shown ahead
`include "pbo_map.svh"
module pbo_fifo #(
  parameter int W = `PBO_PW_WIDTH,
  parameter int D = `PBO_PW_DEPTH
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output wire logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output wire logic out_valid_o,
  input wire logic out_ready_i,
  output wire logic [W-1:0] out_data_o,
  output wire logic [$clog2(D+1)-1:0] count_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;

  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [AW-1:0] nxt_wr = wr_ff + AW'(1);
  wire [AW-1:0] nxt_rd = rd_ff + AW'(1);
  wire [CW-1:0] nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

  assign in_ready_o = cnt_ff != CW'(D);
  assign out_valid_o = cnt_ff != '0;
  assign out_data_o = mem_ff[rd_ff];
  assign count_o = cnt_ff;

  // storage has no reset: entries are only read once written
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ff <= nxt_wr;
      end
      if (pop)
      begin
        rd_ff <= nxt_rd;
      end
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ---- src/pbo_bridge.sv ----
// bridge forwarding: vga decode, palette snoop and transaction ordering
// Notes on behaviour
// - vga mode forwards frame buffer, vga i/o
// - vga mode ignores those addresses from secondary
// - frame buffer reads: single phase, byte enables passed
// - vga i/o: 1KB alias, upper half zero
// - vga mode leaves bios region to windows
// - snoop claims and forwards palette writes
// - mode plus snoop acts as mode alone
// - memory writes posted into internal queue
// - i/o and config writes retried, delayed
// - all reads retried, delayed, data returned
// - no combining, merging or collapsing of writes
// - order fixed when transaction ends without retry
// - retried requests complete in any order
// - both directions independent, concurrent posting
// - posting never waits on delayed transactions
// - posted writes leave in acceptance order
// - delayed read waits for earlier posted writes
// - read completion waits for earlier posted writes
// - delayed write waits for earlier posted writes
// - fair arbiter between posted and delayed
// - delayed requests, completions never pass peers
`include "pbo_map.svh"
module pbo_bridge
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic vga_mode_i,
  input wire logic vga_snoop_i,
  input wire logic [1:0] win_hit_i,
  input wire logic [1:0] req_valid_i,
  input wire pbo_pkg::pbo_cmd_t [1:0] req_cmd_i,
  input wire pbo_pkg::pbo_addr_t [1:0] req_addr_i,
  input wire pbo_pkg::pbo_be_t [1:0] req_be_i,
  input wire pbo_pkg::pbo_data_t [1:0] req_data_i,
  input wire logic [1:0] req_last_i,
  output wire logic [1:0] rsp_claim_o,
  output wire logic [1:0] rsp_accept_o,
  output wire logic [1:0] rsp_retry_o,
  output wire pbo_pkg::pbo_data_t [1:0] rsp_rdata_o,
  output wire logic [1:0] out_valid_o,
  input wire logic [1:0] out_ready_i,
  output wire pbo_pkg::pbo_cmd_t [1:0] out_cmd_o,
  output wire pbo_pkg::pbo_addr_t [1:0] out_addr_o,
  output wire pbo_pkg::pbo_be_t [1:0] out_be_o,
  output wire pbo_pkg::pbo_data_t [1:0] out_data_o,
  output wire logic [1:0] out_last_o,
  output wire logic [1:0] out_single_o,
  input wire pbo_pkg::pbo_data_t [1:0] out_rdata_i
);
  import pbo_pkg::*;

  // index 0: primary to secondary, index 1: secondary to primary
  wire [1:0] pw_pop;
  wire [1:0][`PBO_CNT_W-1:0] pw_cnt;

  for (genvar d = 0; d < 2; d++)
  begin : g_dir
    localparam int O = 1 - d;

    // address and command decode
    wire pbo_addr_t a = req_addr_i[d];
    wire pbo_cmd_t c = req_cmd_i[d];
    wire [`PBO_IO_ALIAS_MSB:0] la = a[`PBO_IO_ALIAS_MSB:0];
    wire up_zero = a[`PBO_IO_UP_MSB:`PBO_IO_UP_LSB] == 16'h0000;
    wire is_io = (c == `PBO_CMD_IOR) | (c == `PBO_CMD_IOW);
    wire is_mrd = (c == `PBO_CMD_MR) | (c == `PBO_CMD_MRM) |
      (c == `PBO_CMD_MRL);
    wire is_post = (c == `PBO_CMD_MW) | (c == `PBO_CMD_MWI);
    wire is_rd = is_mrd | (c == `PBO_CMD_IOR) | (c == `PBO_CMD_CFGR);
    wire is_dwr = (c == `PBO_CMD_IOW) | (c == `PBO_CMD_CFGW);
    wire is_mem = is_mrd | is_post;
    // bits 15:10 never looked at, so every 1KB alias matches
    wire in_vio0 = (la >= `PBO_VIO0_LO) & (la <= `PBO_VIO0_HI);
    wire in_vio1 = (la >= `PBO_VIO1_LO) & (la <= `PBO_VIO1_HI);
    wire vga_io = is_io & up_zero & (in_vio0 | in_vio1);
    wire pal = (c == `PBO_CMD_IOW) & up_zero &
      ((la == `PBO_PAL0) | (la == `PBO_PAL1) | (la == `PBO_PAL2));
    // bios region is left to the base/limit windows on purpose
    wire vga_fb = is_mem & (a >= `PBO_FB_LO) & (a <= `PBO_FB_HI);
    wire vga_hit = vga_mode_i & (vga_io | vga_fb);
    // palette already inside vga i/o, so snoop adds nothing in vga mode
    wire snoop_hit = vga_snoop_i & ~vga_mode_i & pal;
    wire addr_hit;
    if (d == 0)
    begin : g_down
      assign addr_hit = win_hit_i[0] | vga_hit | snoop_hit;
    end
    else
    begin : g_up
      assign addr_hit = ~win_hit_i[1] & ~vga_hit;
    end
    wire claim = req_valid_i[d] & addr_hit & (is_post | is_rd | is_dwr);

    // delayed transaction slot
    pbo_dt_e st_ff;
    pbo_cmd_t s_cmd_ff;
    pbo_addr_t s_addr_ff;
    pbo_be_t s_be_ff;
    pbo_data_t s_data_ff;
    logic s_rd_ff;
    logic s_single_ff;
    pbo_data_t cpl_data_ff;
    logic [`PBO_CNT_W-1:0] dreq_wait_ff;
    logic [`PBO_CNT_W-1:0] cpl_wait_ff;
    logic fair_ff;
    logic hold_ff;
    logic sel_keep_ff;

    // posted queue
    pbo_pw_s pw_in;
    pbo_pw_s pw_head;
    wire pw_in_ready;
    wire pw_out_valid;
    wire pw_out_ready;

    // each write is its own queue entry, never merged with another
    assign pw_in = '{last: req_last_i[d], cmd: c, be: req_be_i[d],
      addr: a, data: req_data_i[d]};

    // one slot: delayed requests cannot pass one another
    wire match = (st_ff != PBO_DT_IDLE) & (c == s_cmd_ff) &
      (a == s_addr_ff) & (req_be_i[d] == s_be_ff) &
      (is_rd | (req_data_i[d] == s_data_ff));
    wire is_dly = is_rd | is_dwr;
    // a different request while the slot is busy is simply retried
    wire take_new = claim & is_dly & (st_ff == PBO_DT_IDLE);
    wire cpl_ok = (st_ff == PBO_DT_DONE) & (cpl_wait_ff == '0);
    wire hand_done = claim & is_dly & match & cpl_ok;
    // posting depends only on room in the queue
    wire post_take = claim & is_post & pw_in_ready;
    wire accept = post_take | hand_done;
    wire retry = claim & ~accept;

    // outbound arbitration
    wire dly_ok = (st_ff == PBO_DT_PEND) & (dreq_wait_ff == '0);
    // alternate when both wait, so neither queue starves
    wire sel_arb = dly_ok & (~pw_out_valid | fair_ff);
    // an offered transfer keeps its source until the target takes it
    wire sel_dly = hold_ff ? sel_keep_ff : sel_arb;
    wire nxt_hold = (pw_out_valid | dly_ok) & ~out_ready_i[d];
    wire issue_dly = sel_dly & out_ready_i[d];
    assign pw_out_ready = out_ready_i[d] & ~sel_dly;
    assign pw_pop[d] = pw_out_valid & pw_out_ready;

    wire nxt_single = (c == `PBO_CMD_MR) | (is_mrd & vga_fb);
    wire [`PBO_CNT_W-1:0] nxt_dreq_wait = take_new ?
      pw_cnt[d] - `PBO_CNT_W'(pw_pop[d]) :
      (pw_pop[d] && dreq_wait_ff != '0) ?
      dreq_wait_ff - `PBO_CNT_W'(1) : dreq_wait_ff;
    wire [`PBO_CNT_W-1:0] nxt_cpl_wait = issue_dly ?
      pw_cnt[O] - `PBO_CNT_W'(pw_pop[O]) :
      (pw_pop[O] && cpl_wait_ff != '0) ?
      cpl_wait_ff - `PBO_CNT_W'(1) : cpl_wait_ff;
    wire nxt_fair = issue_dly ? 1'b0 : pw_pop[d] ? 1'b1 : fair_ff;
    pbo_dt_e nxt_st;
    always_comb
    begin
      nxt_st = st_ff;
      unique case (st_ff)
        PBO_DT_IDLE:
        begin
          if (take_new)
          begin
            nxt_st = PBO_DT_PEND;
          end
        end
        PBO_DT_PEND:
        begin
          if (issue_dly)
          begin
            nxt_st = PBO_DT_DONE;
          end
        end
        PBO_DT_DONE:
        begin
          if (hand_done)
          begin
            nxt_st = PBO_DT_IDLE;
          end
        end
        default:
        begin
          nxt_st = PBO_DT_IDLE;
        end
      endcase
    end

    pbo_fifo #(
      .W(`PBO_PW_WIDTH),
      .D(`PBO_PW_DEPTH)
    ) u_pw (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(claim & is_post),
      .in_ready_o(pw_in_ready),
      .in_data_i(pw_in),
      .out_valid_o(pw_out_valid),
      .out_ready_i(pw_out_ready),
      .out_data_o(pw_head),
      .count_o(pw_cnt[d])
    );

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        st_ff <= PBO_DT_IDLE;
        dreq_wait_ff <= `PBO_CNT_RST;
        cpl_wait_ff <= `PBO_CNT_RST;
        fair_ff <= 1'b0;
        hold_ff <= 1'b0;
        sel_keep_ff <= 1'b0;
      end
      else
      begin
        st_ff <= nxt_st;
        dreq_wait_ff <= nxt_dreq_wait;
        cpl_wait_ff <= nxt_cpl_wait;
        fair_ff <= nxt_fair;
        hold_ff <= nxt_hold;
        sel_keep_ff <= sel_dly;
      end
    end

    // request is captured once, at its first retry
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        s_cmd_ff <= 4'h0;
        s_addr_ff <= `PBO_DATA_RST;
        s_be_ff <= 4'h0;
        s_data_ff <= `PBO_DATA_RST;
        s_rd_ff <= 1'b0;
        s_single_ff <= 1'b0;
      end
      else if (take_new)
      begin
        s_cmd_ff <= c;
        s_addr_ff <= a;
        s_be_ff <= req_be_i[d];
        s_data_ff <= req_data_i[d];
        s_rd_ff <= is_rd;
        s_single_ff <= nxt_single;
      end
    end

    // read data held until the initiator comes back for it
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        cpl_data_ff <= `PBO_DATA_RST;
      end
      else if (issue_dly && s_rd_ff)
      begin
        cpl_data_ff <= out_rdata_i[d];
      end
    end

    assign rsp_claim_o[d] = claim;
    assign rsp_accept_o[d] = accept;
    assign rsp_retry_o[d] = retry;
    assign rsp_rdata_o[d] = cpl_data_ff;
    assign out_valid_o[d] = pw_out_valid | dly_ok;
    assign out_cmd_o[d] = sel_dly ? s_cmd_ff : pw_head.cmd;
    assign out_addr_o[d] = sel_dly ? s_addr_ff : pw_head.addr;
    assign out_be_o[d] = sel_dly ? s_be_ff : pw_head.be;
    assign out_data_o[d] = sel_dly ? s_data_ff : pw_head.data;
    assign out_last_o[d] = sel_dly | pw_head.last;
    assign out_single_o[d] = sel_dly & s_single_ff;
  end
endmodule

// ---- bench/pbo_tgt_model.sv ----
// far-side target model for the downstream bus
module pbo_tgt_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire pbo_pkg::pbo_cmd_t cmd_i,
  input wire pbo_pkg::pbo_addr_t addr_i,
  input wire pbo_pkg::pbo_data_t data_i,
  input wire pbo_pkg::pbo_be_t be_i,
  input wire logic last_i,
  output logic ready_o,
  output pbo_pkg::pbo_data_t rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbo_pkg::*;
  pbo_cmd_t cmd_q [$];
  pbo_data_t dat_q [$];
  pbo_be_t be_q [$];
  logic lst_q [$];
  wire logic go = valid_i && !stall_i && !ready_o;
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      ready_o <= 1'b0;
      rdata_o <= 32'h00000000;
      cmd_q.delete();
      dat_q.delete();
      be_q.delete();
      lst_q.delete();
    end
    else
    begin
      if (valid_i && ready_o)
      begin
        cmd_q.push_back(cmd_i);
        dat_q.push_back(data_i);
        be_q.push_back(be_i);
        lst_q.push_back(last_i);
      end
      // ready never waits on any delayed transfer
      ready_o <= go;
      // idle data toggles so a stale word cannot pass
      rdata_o <= go ? addr_i ^ 32'h5A5A0000 : ~rdata_o;
    end
endmodule

// ---- bench/pbo_bridge_props.sv ----
// assertions on the bridge forwarding ports
`include "pbo_map.svh"
module pbo_bridge_props
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic vga_mode_i,
  input wire logic vga_snoop_i,
  input wire logic [1:0] win_hit_i,
  input wire logic [1:0] req_valid_i,
  input wire pbo_pkg::pbo_cmd_t [1:0] req_cmd_i,
  input wire pbo_pkg::pbo_addr_t [1:0] req_addr_i,
  input wire logic [1:0] rsp_claim_o,
  input wire logic [1:0] rsp_accept_o,
  input wire logic [1:0] out_valid_o,
  input wire logic [1:0] out_ready_i,
  input wire pbo_pkg::pbo_cmd_t [1:0] out_cmd_o,
  input wire pbo_pkg::pbo_addr_t [1:0] out_addr_o,
  input wire logic [1:0] out_single_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbo_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire pbo_addr_t a0 = req_addr_i[0];
  wire pbo_addr_t a1 = req_addr_i[1];
  wire logic [9:0] lo = a0[9:0];
  wire logic up0 = a0[31:16] == 16'h0000;
  wire logic fb0 = a0 >= `PBO_FB_LO && a0 <= `PBO_FB_HI;
  wire logic fb1 = a1 >= `PBO_FB_LO && a1 <= `PBO_FB_HI;
  wire logic m1 = req_cmd_i[1] inside {`PBO_CMD_MR, `PBO_CMD_MW,
    `PBO_CMD_MRM, `PBO_CMD_MRL, `PBO_CMD_MWI};
  wire logic vio = up0 && (lo >= `PBO_VIO0_LO && lo <= `PBO_VIO0_HI
    || lo >= `PBO_VIO1_LO && lo <= `PBO_VIO1_HI);
  wire logic pal = up0 && (lo == `PBO_PAL0 || lo == `PBO_PAL1
    || lo == `PBO_PAL2);
  wire logic v0 = req_valid_i[0];
  wire pbo_cmd_t c0 = req_cmd_i[0];
  sequence s_posted;
    rsp_accept_o[0] && c0 == `PBO_CMD_MW;
  endsequence
  sequence s_held;
    out_valid_o[0] && !out_ready_i[0];
  endsequence
  a_fb_forward:
    assert property (vga_mode_i && v0 && c0 == `PBO_CMD_MR && fb0
      |-> rsp_claim_o[0]) else $error("frame read not claimed");
  a_fb_up_ignore:
    assert property (vga_mode_i && req_valid_i[1] && fb1 && m1
      |-> !rsp_claim_o[1]) else $error("upstream frame claimed");
  a_vio_claim:
    assert property (vga_mode_i && v0 && c0 == `PBO_CMD_IOR && vio
      |-> rsp_claim_o[0]) else $error("vga io not claimed");
  a_bios_pass:
    assert property (vga_mode_i && !win_hit_i[0] && v0 && a0[31:16] ==
      16'h000C |-> !rsp_claim_o[0]) else $error("bios claimed");
  a_pal_claim:
    assert property (vga_snoop_i && v0 && c0 == `PBO_CMD_IOW && pal
      |-> rsp_claim_o[0]) else $error("palette not claimed");
  a_single_read:
    assert property (out_valid_o[0] && out_cmd_o[0] == `PBO_CMD_MR
      |-> out_single_o[0]) else $error("read not single");
  a_post_shown:
    assert property (s_posted |=> out_valid_o[0])
      else $error("posted write not queued");
  a_out_hold:
    assert property (s_held |=> out_valid_o[0] && $stable(out_addr_o[0])
      && $stable(out_cmd_o[0])) else $error("outbound changed");
endmodule
bind pbo_bridge pbo_bridge_props u_pbo_bridge_props (.*);

// ---- bench/tb_top.sv ----
// bench for the bridge forwarding and ordering block
`include "pbo_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pbo_pkg::*;
  logic clk, nrst, mode, snoop, stall, rdy1, r_clm, r_acc, r_rty;
  logic [1:0] win, rv, lst;
  pbo_cmd_t [1:0] cmd;
  pbo_addr_t [1:0] adr;
  pbo_be_t [1:0] be;
  pbo_data_t [1:0] wd;
  pbo_data_t r_dat;
  wire logic [1:0] clm, acc, rty, ov, rdy;
  wire pbo_data_t [1:0] rsd, od, ird;
  wire pbo_cmd_t [1:0] oc;
  wire pbo_addr_t [1:0] oa;
  wire pbo_be_t [1:0] obe;
  wire logic [1:0] olst;
  int n_fail;
  int samples_checked;
  assign rdy[1] = rdy1;
  assign ird[1] = 32'h00000000;
  pbo_bridge u_pbo_bridge (.clk_i(clk), .nrst_i(nrst), .vga_mode_i(mode),
    .vga_snoop_i(snoop), .win_hit_i(win), .req_valid_i(rv),
    .req_cmd_i(cmd), .req_addr_i(adr), .req_be_i(be), .req_data_i(wd),
    .req_last_i(lst), .rsp_claim_o(clm), .rsp_accept_o(acc),
    .rsp_retry_o(rty), .rsp_rdata_o(rsd), .out_valid_o(ov),
    .out_ready_i(rdy), .out_cmd_o(oc), .out_addr_o(oa), .out_be_o(obe),
    .out_data_o(od), .out_last_o(olst), .out_single_o(),
    .out_rdata_i(ird));
  pbo_tgt_model u_pbo_tgt_model (.clk_i(clk), .nrst_i(nrst),
    .stall_i(stall), .valid_i(ov[0]), .cmd_i(oc[0]), .addr_i(oa[0]),
    .data_i(od[0]), .be_i(obe[0]), .last_i(olst[0]), .ready_o(rdy[0]),
    .rdata_o(ird[0]));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task rst;
    nrst = 1'b0;
    rv = 2'b00;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
  endtask
  task req(input int d, input pbo_cmd_t c, input pbo_addr_t a,
    input pbo_data_t w, input pbo_be_t b);
    cmd[d] = c;
    adr[d] = a;
    wd[d] = w;
    be[d] = b;
    rv = 2'(1 << d);
    #98;
    r_clm = clm[d];
    r_acc = acc[d];
    r_rty = rty[d];
    r_dat = rsd[d];
    @(posedge clk);
    #1;
  endtask
  task idle;
    rv = 2'b00;
    @(posedge clk);
    #1;
  endtask
  task wlog(input int n);
    for (int i = 0; i < 200 && u_pbo_tgt_model.cmd_q.size() < n; i++)
      @(posedge clk);
    #1;
  endtask
  // initiator keeps repeating the same request until it completes
  task rpt(input pbo_cmd_t c, input pbo_addr_t a, input pbo_be_t b);
    for (int k = 0; k < 20; k++)
    begin
      req(0, c, a, 32'h00000044, b);
      if (r_acc)
        break;
    end
    chk(r_acc, 1'b1);
  endtask
  task t_decode;
    logic [39:0] tv [13];
    tv = '{40'h96000A0000, 40'h96000BFFFF, 40'h86000C0000, 40'h920000FFBB,
      40'h82000103B0, 40'h82000003BC, 40'h92000003DF, 40'h53000007C6,
      40'h43000003C7, 40'h42000003C8, 40'hD2000003C7, 40'hA6000A0000,
      40'h03000003C9};
    win = 2'b00;
    foreach (tv[i])
    begin
      rst;
      mode = tv[i][39];
      snoop = tv[i][38];
      req(tv[i][37], tv[i][35:32], tv[i][31:0], 32'h00000000, 4'hF);
      chk(r_clm, tv[i][36]);
    end
    $display("decode test done");
  endtask
  task t_fill;
    rst;
    win = 2'b01;
    stall = 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      lst[0] = 1'(i % 2);
      req(0, `PBO_CMD_MW, 32'h00001000 + 32'(i / 2) * 4, i, 4'hF);
      chk(r_acc, i < 16);
      chk(r_rty, i == 16);
    end
    idle;
    stall = 1'b0;
    lst[0] = 1'b1;
    wlog(16);
    for (int i = 0; i < 16; i++)
    begin
      chk(u_pbo_tgt_model.dat_q[i], i);
      chk(u_pbo_tgt_model.lst_q[i], i % 2);
    end
    repeat (4) @(posedge clk);
    #1;
    chk(u_pbo_tgt_model.dat_q.size(), 16);
    chk(ov[0], 1'b0);
    $display("fill test done");
  endtask
  task t_read;
    rst;
    win = 2'b01;
    stall = 1'b1;
    req(0, `PBO_CMD_MW, 32'h00002000, 32'h00000011, 4'hF);
    chk(r_acc, 1'b1);
    req(0, `PBO_CMD_MR, 32'h00003000, 32'h00000044, 4'h3);
    chk(r_rty, 1'b1);
    req(0, `PBO_CMD_MW, 32'h00002004, 32'h00000022, 4'hF);
    chk(r_acc, 1'b1);
    idle;
    stall = 1'b0;
    wlog(3);
    chk(u_pbo_tgt_model.cmd_q[0], `PBO_CMD_MW);
    chk(u_pbo_tgt_model.cmd_q[1], `PBO_CMD_MR);
    chk(u_pbo_tgt_model.cmd_q[2], `PBO_CMD_MW);
    chk(u_pbo_tgt_model.be_q[1], 4'h3);
    rpt(`PBO_CMD_MR, 32'h00003000, 4'h3);
    chk(r_dat, 32'h5A5A3000);
    $display("read test done");
  endtask
  task t_iow;
    rst;
    win = 2'b00;
    mode = 1'b1;
    stall = 1'b1;
    req(0, `PBO_CMD_MW, 32'h000A0000, 32'h00000033, 4'hF);
    chk(r_acc, 1'b1);
    repeat (2)
    begin
      req(0, `PBO_CMD_IOW, 32'h000003B0, 32'h00000044, 4'hF);
      chk(r_rty, 1'b1);
    end
    idle;
    stall = 1'b0;
    wlog(2);
    chk(u_pbo_tgt_model.cmd_q[1], `PBO_CMD_IOW);
    rpt(`PBO_CMD_IOW, 32'h000003B0, 4'hF);
    $display("io write test done");
  endtask
  // upstream posted write must drain before the read data goes back
  task t_cpl;
    rst;
    win = 2'b01;
    rdy1 = 1'b0;
    req(1, `PBO_CMD_MW, 32'h00007000, 32'h00000055, 4'hF);
    chk(r_acc, 1'b1);
    req(0, `PBO_CMD_MR, 32'h00008000, 32'h00000044, 4'hF);
    chk(r_rty, 1'b1);
    idle;
    wlog(1);
    req(0, `PBO_CMD_MR, 32'h00008000, 32'h00000044, 4'hF);
    chk(r_rty, 1'b1);
    rdy1 = 1'b1;
    rpt(`PBO_CMD_MR, 32'h00008000, 4'hF);
    chk(r_dat, 32'h5A5A8000);
    $display("completion order test done");
  endtask
  task t_both;
    rst;
    win = 2'b01;
    cmd = {`PBO_CMD_MW, `PBO_CMD_MW};
    adr = {32'h00006000, 32'h00005000};
    rv = 2'b11;
    #98;
    chk(acc, 2'b11);
    @(posedge clk);
    #1;
    rv = 2'b00;
    #98;
    chk(ov, 2'b11);
    $display("both directions test done");
  endtask
  // tests need about two hundred cycles; cut off at three thousand
  initial
  begin
    #300000;
    n_fail++;
    test_done;
  end
  initial
  begin
    {nrst, mode, snoop, stall, win, rv, cmd, adr, be, wd} = '0;
    {rdy1, lst} = 3'b111;
    n_fail = 0;
    samples_checked = 0;
    @(posedge clk);
    #1;
    t_decode;
    t_fill;
    t_read;
    t_iow;
    t_cpl;
    t_both;
    test_done;
  end
endmodule
